// ### occ_defines.svh
// Register indices, field positions, reset values and timing for the on-chip oscillator clock control.
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define OCC_IDX_TRIM32_SECOND 8'h15
`define OCC_IDX_HS_CTL 8'h23
`define OCC_IDX_TRIM_FIRST 8'h24
`define OCC_IDX_HS_DIV 8'h25
`define OCC_IDX_PRESCALER 8'h28
`define OCC_IDX_TRIM36_FIRST 8'h29
`define OCC_IDX_TRIM36_SECOND 8'h2a
`define OCC_IDX_TRIM32_FIRST 8'h2b
`define OCC_IDX_TRIM_SECOND 8'h2f
`define OCC_IDX_PWR_DETECT 8'h34
`define OCC_IDX_PROTECT 8'h40
`define OCC_IDX_SYSCLK 8'h41
`define OCC_IDX_STATUS 8'h42

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OCC_HS_EN_BIT 0
`define OCC_HS_SEL_BIT 1
`define OCC_DIV128_SEL_BIT 3
`define OCC_PRESCALER_RST_BIT 7
`define OCC_LOW_CONS_BIT 0
`define OCC_DETECT0_BIT 5
`define OCC_ALL_STOP_BIT 0
`define OCC_XIN_STOP_BIT 1
`define OCC_LOW_OSC_STOP_BIT 2
`define OCC_PIN_SWITCH_BIT 3
`define OCC_SYS_SEL_BIT 4
`define OCC_CLK_UNLOCK_BIT 0
`define OCC_VOLT_UNLOCK_BIT 3

// ----------------------------------------------------------------------------
// Write masks and reset values
// ----------------------------------------------------------------------------
`define OCC_HS_CTL_MASK 8'h0f
`define OCC_HS_DIV_MASK 8'hff
`define OCC_PWR_MASK 8'he1
`define OCC_PROTECT_MASK 8'h09
`define OCC_HS_CTL_RST 8'h00
`define OCC_HS_DIV_RST 8'h00
`define OCC_TRIM_FIRST_RST 8'h80
`define OCC_TRIM_SECOND_RST 8'h80
`define OCC_PWR_RST_AUTO 8'h00
`define OCC_PWR_RST_MANUAL 8'h20
`define OCC_SYSCLK_RST 8'h12
`define OCC_PROTECT_RST 8'h00
`define OCC_DIV_OFFSET 4'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OCC_CLK_PERIOD_NS 10
`define OCC_DETECT_DELAY_US 300

`endif

// ### occ_pkg.sv
// Types shared by the on-chip oscillator clock control files.
package occ_pkg;
	typedef logic [7:0] occ_byte_t;
	typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ACK} occ_bus_e;
endpackage : occ_pkg

// ### occ_trim_rom.sv
// Factory frequency correction bytes, read through a registered output.
module occ_trim_rom #(
	parameter occ_pkg::occ_byte_t TRIM36_FIRST = 8'h11,
	parameter occ_pkg::occ_byte_t TRIM36_SECOND = 8'h22,
	parameter occ_pkg::occ_byte_t TRIM32_FIRST = 8'h33,
	parameter occ_pkg::occ_byte_t TRIM32_SECOND = 8'h44
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] addr,
	output occ_pkg::occ_byte_t data
);
	// ------------------------------------------------------------------------
	// Contents
	// ------------------------------------------------------------------------
	// The bytes are fixed at build time; no path can write them.
	occ_pkg::occ_byte_t word_sel;
	assign word_sel = (addr == 2'h0) ? TRIM36_FIRST :
		(addr == 2'h1) ? TRIM36_SECOND :
		(addr == 2'h2) ? TRIM32_FIRST : TRIM32_SECOND;

	// Registered read port; data lag the address by one cycle.
	always_ff @(posedge clock) begin
		if (rst) begin
			data <= 8'h00;
		end else begin
			data <= word_sel;
		end
	end
endmodule : occ_trim_rom

// ### occ_clock_control.sv
// On-chip oscillator clock control with a classic Wishbone register slave.
//
// The Wishbone slave port was decided locally.
`include "occ_defines.svh"

// Function
// [R1] High-speed oscillator runs only while its enable bit is one.
// [R2] Oscillator clock comes from low-speed at select zero, high-speed at one.
// [R3] Divide-by-128 clock source: low-speed at zero, divided high-speed at one.
// [R4] Software changes the select only with enable set and low-speed running.
// [R5] Software clears select before clearing enable, in separate writes.
// [R6] Software waits one low-speed period before stopping the low-speed oscillator.
// [R7] Software sets the clock unlock bit before writing clock registers.
// [R8] Software rewrites trim registers only while the high-speed oscillator is off.
// [R9] Trim reset values give 40 MHz; copy correction bytes for other rates.
// [R10] Four read-only factory correction bytes for 36.864 and 32 MHz.
// [R11] Divide code 000 to 111 selects divide-by-2 to divide-by-9.
// [R12] Writing one to prescaler reset initialises the prescaler; reads zero.
// [R13] Low-consumption bit reduces internal power; used only entering wait mode.
// [R14] Software never enters stop mode while low consumption is enabled.
// [R15] Three enable bits turn voltage detection circuits 0 to 2 on.
// [R16] Detection circuits 1 and 2 work only after the enable delay.
// [R17] Detect register reset depends on the autostart option strap.
// [R18] Software writes detect-0 enable with reset value, after voltage unlock.
// [R19] Main oscillator stopped during reset and until software enables it.
// [R20] Main oscillator runs when pin switch set and stop bit cleared.
// [R21] Stop bit stops the main oscillator but not an external clock.
// [R22] Stop mode halts every clock and disconnects the feedback resistor.
// [R23] Pin switch bit is sticky once written to one.
// [R24] Low-speed stop bit forced to zero while on-chip clock is selected.
// [R25] Writes to protected registers are ignored while their unlock bit is zero.
module occ_clock_control #(
	parameter int DETECT_DELAY_CYCLES = (`OCC_DETECT_DELAY_US * 1000 + `OCC_CLK_PERIOD_NS - 1) / `OCC_CLK_PERIOD_NS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic lvd0_autostart,
	input wire logic stop_wake,
	output logic hs_osc_run,
	output logic osc_clock_high_sel,
	output logic div128_src_high,
	output logic [3:0] hs_div_ratio,
	output occ_pkg::occ_byte_t hs_trim_first_out,
	output occ_pkg::occ_byte_t hs_trim_second_out,
	output logic prescaler_init,
	output logic low_consumption,
	output logic [2:0] detect_enable,
	output logic [2:0] detect_ready,
	output logic main_osc_run,
	output logic main_feedback_enable,
	output logic cpu_src_main,
	output logic low_osc_run,
	output logic all_clocks_stopped
);
	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Address compare shared by the decoder, the read mux and the assertions.
	function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] want);
		return idx == want;
	endfunction : idx_hit

	// ------------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------------
	occ_pkg::occ_bus_e bus_state_reg, bus_state_next;
	occ_pkg::occ_byte_t hs_ctl_reg, hs_ctl_next;
	occ_pkg::occ_byte_t hs_div_reg, hs_div_next;
	occ_pkg::occ_byte_t trim_first_reg, trim_first_next;
	occ_pkg::occ_byte_t trim_second_reg, trim_second_next;
	occ_pkg::occ_byte_t pwr_reg, pwr_next;
	occ_pkg::occ_byte_t protect_reg, protect_next;
	logic all_stop_reg, all_stop_next;
	logic xin_stop_reg, xin_stop_next;
	logic low_osc_stop_reg, low_osc_stop_next;
	logic pin_switch_reg, pin_switch_next;
	logic sys_sel_reg, sys_sel_next;
	logic [31:0] rd_data_reg, rd_data_next;
	logic [15:0] det_cnt_reg [1:2];
	occ_pkg::occ_byte_t rom_data;
	logic [1:0] rom_addr;

	// ------------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------------
	// A write lands at the edge that ends the ack cycle, the same edge at which
	// the master samples ack, so an access aborted in the wait cycle changes nothing.
	wire [7:0] idx = wb_adr_i[9:2];
	wire occ_pkg::occ_byte_t wd = wb_dat_i[7:0];
	wire bus_req = wb_cyc_i & wb_stb_i;
	wire wr = (bus_state_reg == occ_pkg::BUS_ACK) & bus_req & wb_we_i & wb_sel_i[0];
	wire clk_unlock = protect_reg[`OCC_CLK_UNLOCK_BIT];
	wire volt_unlock = protect_reg[`OCC_VOLT_UNLOCK_BIT];
	wire wr_hs_ctl = wr & idx_hit(idx, `OCC_IDX_HS_CTL) & clk_unlock; // R7 R25
	wire wr_hs_div = wr & idx_hit(idx, `OCC_IDX_HS_DIV) & clk_unlock; // R25
	wire wr_trim_first = wr & idx_hit(idx, `OCC_IDX_TRIM_FIRST) & clk_unlock; // R25
	wire wr_trim_second = wr & idx_hit(idx, `OCC_IDX_TRIM_SECOND) & clk_unlock; // R25
	wire wr_pwr = wr & idx_hit(idx, `OCC_IDX_PWR_DETECT) & volt_unlock; // R18 R25
	wire wr_sysclk = wr & idx_hit(idx, `OCC_IDX_SYSCLK) & clk_unlock; // R25
	wire wr_protect = wr & idx_hit(idx, `OCC_IDX_PROTECT);
	wire wr_prescaler = wr & idx_hit(idx, `OCC_IDX_PRESCALER) & wd[`OCC_PRESCALER_RST_BIT]; // R12

	// ------------------------------------------------------------------------
	// Next values of the software registers
	// ------------------------------------------------------------------------
	// Factory trim reset values give the 40 MHz setting; other rates come from
	// copying correction bytes in. The trims are not locked against a running
	// oscillator, software must stop it first.
	assign hs_ctl_next = wr_hs_ctl ? (wd & `OCC_HS_CTL_MASK) : hs_ctl_reg;
	assign hs_div_next = wr_hs_div ? (wd & `OCC_HS_DIV_MASK) : hs_div_reg;
	assign trim_first_next = wr_trim_first ? wd : trim_first_reg; // R9
	assign trim_second_next = wr_trim_second ? wd : trim_second_reg; // R9
	assign pwr_next = wr_pwr ? (wd & `OCC_PWR_MASK) : pwr_reg; // R15
	assign protect_next = wr_protect ? (wd & `OCC_PROTECT_MASK) : protect_reg;
	assign pin_switch_next = pin_switch_reg | (wr_sysclk & wd[`OCC_PIN_SWITCH_BIT]); // R23
	assign sys_sel_next = wr_sysclk ? wd[`OCC_SYS_SEL_BIT] : sys_sel_reg;
	assign xin_stop_next = wr_sysclk ? wd[`OCC_XIN_STOP_BIT] : xin_stop_reg;
	// A wake request in the same cycle as a stop write loses: the write wins.
	assign all_stop_next = wr_sysclk ? wd[`OCC_ALL_STOP_BIT] : (stop_wake ? 1'b0 : all_stop_reg);
	// The low-speed oscillator may only be stopped while the main clock is selected.
	assign low_osc_stop_next = sys_sel_next ? 1'b0 : (wr_sysclk ? wd[`OCC_LOW_OSC_STOP_BIT] : low_osc_stop_reg); // R24

	// ------------------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------------------
	// The factory bytes come out of the memory one cycle after the address,
	// which is why every access spends one wait cycle.
	assign rom_addr = idx_hit(idx, `OCC_IDX_TRIM36_FIRST) ? 2'h0 :
		idx_hit(idx, `OCC_IDX_TRIM36_SECOND) ? 2'h1 :
		idx_hit(idx, `OCC_IDX_TRIM32_FIRST) ? 2'h2 : 2'h3;

	always_comb begin
		rd_data_next = 32'h0000_0000;
		if (idx_hit(idx, `OCC_IDX_HS_CTL)) begin
			rd_data_next[7:0] = hs_ctl_reg;
		end else if (idx_hit(idx, `OCC_IDX_HS_DIV)) begin
			rd_data_next[7:0] = hs_div_reg;
		end else if (idx_hit(idx, `OCC_IDX_TRIM_FIRST)) begin
			rd_data_next[7:0] = trim_first_reg;
		end else if (idx_hit(idx, `OCC_IDX_TRIM_SECOND)) begin
			rd_data_next[7:0] = trim_second_reg;
		end else if (idx_hit(idx, `OCC_IDX_TRIM36_FIRST) || idx_hit(idx, `OCC_IDX_TRIM36_SECOND) ||
			idx_hit(idx, `OCC_IDX_TRIM32_FIRST) || idx_hit(idx, `OCC_IDX_TRIM32_SECOND)) begin
			rd_data_next[7:0] = rom_data; // R10
		end else if (idx_hit(idx, `OCC_IDX_PWR_DETECT)) begin
			rd_data_next[7:0] = pwr_reg;
		end else if (idx_hit(idx, `OCC_IDX_PROTECT)) begin
			rd_data_next[7:0] = protect_reg;
		end else if (idx_hit(idx, `OCC_IDX_SYSCLK)) begin
			rd_data_next[7:0] = {3'h0, sys_sel_reg, pin_switch_reg, low_osc_stop_reg, xin_stop_reg, all_stop_reg};
		end else if (idx_hit(idx, `OCC_IDX_STATUS)) begin
			rd_data_next[7:0] = {1'b0, detect_ready, all_stop_reg, main_osc_run, low_osc_run, hs_osc_run};
		end else begin
			rd_data_next = 32'h0000_0000; // R12
		end
	end

	// ------------------------------------------------------------------------
	// Bus state machine
	// ------------------------------------------------------------------------
	// A master that drops its strobe in the wait cycle returns the slave to idle with no ack.
	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			occ_pkg::BUS_IDLE: begin
				if (bus_req) begin
					bus_state_next = occ_pkg::BUS_WAIT;
				end
			end
			occ_pkg::BUS_WAIT: begin
				bus_state_next = bus_req ? occ_pkg::BUS_ACK : occ_pkg::BUS_IDLE;
			end
			default: begin
				bus_state_next = occ_pkg::BUS_IDLE;
			end
		endcase
	end

	// Ack comes straight from the state register, so it is a clean one-cycle pulse.
	assign wb_ack_o = (bus_state_reg == occ_pkg::BUS_ACK);

	// Read data are captured in the wait cycle and held until the next access.
	always_ff @(posedge clock) begin
		if (rst) begin
			bus_state_reg <= occ_pkg::BUS_IDLE;
			rd_data_reg <= 32'h0000_0000;
		end else begin
			bus_state_reg <= bus_state_next;
			rd_data_reg <= (bus_state_reg == occ_pkg::BUS_WAIT) ? rd_data_next : rd_data_reg;
		end
	end

	// The upper read lanes stay zero because every register is one byte wide.
	assign wb_dat_o = rd_data_reg;

	// ------------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------------
	// The detect register reset follows the autostart strap; the reset is
	// synchronous, so the strap is sampled at a clock edge.
	always_ff @(posedge clock) begin
		if (rst) begin
			hs_ctl_reg <= `OCC_HS_CTL_RST;
			hs_div_reg <= `OCC_HS_DIV_RST;
			trim_first_reg <= `OCC_TRIM_FIRST_RST;
			trim_second_reg <= `OCC_TRIM_SECOND_RST;
			pwr_reg <= lvd0_autostart ? `OCC_PWR_RST_AUTO : `OCC_PWR_RST_MANUAL; // R17
			protect_reg <= `OCC_PROTECT_RST;
			{sys_sel_reg, pin_switch_reg, low_osc_stop_reg, xin_stop_reg, all_stop_reg} <= 5'(`OCC_SYSCLK_RST); // R19
		end else begin
			hs_ctl_reg <= hs_ctl_next;
			hs_div_reg <= hs_div_next;
			trim_first_reg <= trim_first_next;
			trim_second_reg <= trim_second_next;
			pwr_reg <= pwr_next;
			protect_reg <= protect_next;
			{sys_sel_reg, pin_switch_reg, low_osc_stop_reg, xin_stop_reg, all_stop_reg} <=
				{sys_sel_next, pin_switch_next, low_osc_stop_next, xin_stop_next, all_stop_next};
		end
	end

	// ------------------------------------------------------------------------
	// Detection enable delay
	// ------------------------------------------------------------------------
	// Circuits 1 and 2 count from the enable rising; clearing the enable
	// restarts the count, so a quick off-on still waits the full delay.
	always_ff @(posedge clock) begin
		for (int i = 1; i <= 2; i++) begin
			if (rst || !pwr_reg[`OCC_DETECT0_BIT + i]) begin
				det_cnt_reg[i] <= 16'h0000;
			end else if (det_cnt_reg[i] != 16'(DETECT_DELAY_CYCLES)) begin
				det_cnt_reg[i] <= det_cnt_reg[i] + 16'h0001; // R16
			end
		end
	end

	// ------------------------------------------------------------------------
	// Clock control outputs
	// ------------------------------------------------------------------------
	// Stop mode overrides every run output; the select outputs keep their
	// values so the clock tree resumes on the same source after wake.
	always_ff @(posedge clock) begin
		if (rst) begin
			hs_osc_run <= 1'b0;
			osc_clock_high_sel <= 1'b0;
			div128_src_high <= 1'b0;
			hs_div_ratio <= `OCC_DIV_OFFSET;
			hs_trim_first_out <= `OCC_TRIM_FIRST_RST;
			hs_trim_second_out <= `OCC_TRIM_SECOND_RST;
			prescaler_init <= 1'b0;
			low_consumption <= 1'b0;
			detect_enable <= 3'h0;
			detect_ready <= 3'h0;
			main_osc_run <= 1'b0;
			main_feedback_enable <= 1'b0;
			cpu_src_main <= 1'b0;
			low_osc_run <= 1'b0;
			all_clocks_stopped <= 1'b0;
		end else begin
			hs_osc_run <= hs_ctl_reg[`OCC_HS_EN_BIT] & ~all_stop_reg; // R1 R22
			osc_clock_high_sel <= hs_ctl_reg[`OCC_HS_SEL_BIT]; // R2
			div128_src_high <= hs_ctl_reg[`OCC_DIV128_SEL_BIT]; // R3
			hs_div_ratio <= {1'b0, hs_div_reg[2:0]} + `OCC_DIV_OFFSET; // R11
			hs_trim_first_out <= trim_first_reg;
			hs_trim_second_out <= trim_second_reg;
			prescaler_init <= wr_prescaler; // R12
			low_consumption <= pwr_reg[`OCC_LOW_CONS_BIT]; // R13
			detect_enable <= pwr_reg[7:5]; // R15
			detect_ready[0] <= pwr_reg[`OCC_DETECT0_BIT];
			detect_ready[1] <= det_cnt_reg[1] == 16'(DETECT_DELAY_CYCLES); // R16
			detect_ready[2] <= det_cnt_reg[2] == 16'(DETECT_DELAY_CYCLES); // R16
			main_osc_run <= pin_switch_reg & ~xin_stop_reg & ~all_stop_reg; // R20 R21 R22
			main_feedback_enable <= pin_switch_reg & ~all_stop_reg; // R22
			cpu_src_main <= ~sys_sel_reg; // R20
			low_osc_run <= ~low_osc_stop_reg & ~all_stop_reg; // R22
			all_clocks_stopped <= all_stop_reg; // R22
		end
	end

	// ------------------------------------------------------------------------
	// Correction byte memory
	// ------------------------------------------------------------------------
	// The memory shares the bus reset so its read register starts from a known value.
	occ_trim_rom u_trim_rom (
		.clock(clock),
		.rst(rst),
		.addr(rom_addr),
		.data(rom_data)
	);

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	// Every check runs on the one bus clock and is quiet while reset is high.
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_hs_run_enable: assert property (hs_osc_run |-> $past(hs_ctl_reg[`OCC_HS_EN_BIT])) // R1
		else $error("high-speed oscillator runs without enable");
	a_osc_sel_follow: assert property (##1 osc_clock_high_sel == $past(hs_ctl_reg[`OCC_HS_SEL_BIT])) // R2
		else $error("oscillator select output wrong");
	a_div128_source: assert property (hs_ctl_reg[`OCC_DIV128_SEL_BIT] && $stable(hs_ctl_reg) |=> div128_src_high) // R3
		else $error("divide-by-128 source wrong");
	a_div_ratio_map: assert property (##1 hs_div_ratio == 4'($past(hs_div_reg[2:0])) + 4'h2) // R11
		else $error("divide ratio not code plus two");
	a_prescaler_pulse: assert property (wr_prescaler |=> prescaler_init ##1 !prescaler_init) // R12
		else $error("prescaler init not a one-cycle pulse");
	a_prescaler_reads_zero: assert property (wb_ack_o && !wb_we_i && idx_hit(idx, `OCC_IDX_PRESCALER)
		|-> wb_dat_o == 32'h0000_0000) // R12
		else $error("prescaler reset register read nonzero");
	a_detect_delay_wait: assert property ($rose(pwr_reg[6]) |=> !detect_ready[1] [*2]) // R16
		else $error("detection 1 ready before its delay");
	a_pin_switch_sticky: assert property (pin_switch_reg |=> pin_switch_reg) // R23
		else $error("pin switch bit cleared");
	a_low_osc_forced: assert property (sys_sel_reg |-> !low_osc_stop_reg) // R24
		else $error("low-speed stop set while on-chip clock selected");
	a_locked_hold: assert property (wr && idx_hit(idx, `OCC_IDX_HS_CTL) && !clk_unlock |=> $stable(hs_ctl_reg)) // R25
		else $error("locked oscillator control register changed");
	a_main_run_cause: assert property (main_osc_run |-> $past(pin_switch_reg && !xin_stop_reg)) // R20
		else $error("main oscillator runs without pin switch and start");
	a_stop_all_clocks: assert property (all_stop_reg |=> !hs_osc_run && !main_osc_run && !main_feedback_enable) // R22
		else $error("a clock runs in stop mode");
	a_stop_low_osc: assert property (all_stop_reg |=> !low_osc_run && all_clocks_stopped) // R22
		else $error("low-speed oscillator runs in stop mode");
	a_xin_stop_halts: assert property (xin_stop_reg |=> !main_osc_run) // R21
		else $error("main oscillator runs with its stop bit set");
	a_volt_locked_hold: assert property (wr && idx_hit(idx, `OCC_IDX_PWR_DETECT) && !volt_unlock // R25
		|=> $stable(pwr_reg))
		else $error("locked detect register changed");
	// Outputs that mirror a register one clock later; both agree in reset.
	a_low_cons_follow: assert property (##1 low_consumption == $past(pwr_reg[`OCC_LOW_CONS_BIT])) // R13
		else $error("low consumption output wrong");
	a_trim_out_follow: assert property (##1 hs_trim_first_out == $past(trim_first_reg)) // R9
		else $error("first trim output wrong");

	// Covers for the main scenarios.
	c_hs_selected: cover property (hs_osc_run && osc_clock_high_sel);
	c_main_running: cover property (main_osc_run && cpu_src_main);
	c_detect1_ready: cover property ($rose(detect_ready[1]));
	c_stop_wake: cover property (all_stop_reg ##1 !all_stop_reg);
	c_locked_write: cover property (wr && idx_hit(idx, `OCC_IDX_HS_CTL) && !clk_unlock);
endmodule : occ_clock_control

// ### occ_clock_control_tb.sv
// Self-checking testbench for the on-chip oscillator clock control block.
`include "occ_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module occ_clock_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DELAY = 8;
	logic clock, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, lvd0_autostart, stop_wake;
	logic hs_osc_run, osc_clock_high_sel, div128_src_high, prescaler_init, low_consumption;
	logic main_osc_run, main_feedback_enable, cpu_src_main, low_osc_run, all_clocks_stopped;
	logic [9:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i, hs_div_ratio;
	logic [2:0] detect_enable, detect_ready;
	occ_pkg::occ_byte_t hs_trim_first_out, hs_trim_second_out;
	logic [7:0] rd, v;
	logic [4:0] fl;
	int n_errors = 0, checks = 0, pulses = 0;
	integer seed = 32'hd544;
	// Small delay count keeps the detection settle time short in simulation.
	occ_clock_control #(.DETECT_DELAY_CYCLES(DELAY)) dut (.clock(clock), .rst(rst), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .lvd0_autostart(lvd0_autostart), .stop_wake(stop_wake),
		.hs_osc_run(hs_osc_run), .osc_clock_high_sel(osc_clock_high_sel), .div128_src_high(div128_src_high),
		.hs_div_ratio(hs_div_ratio), .hs_trim_first_out(hs_trim_first_out), .hs_trim_second_out(hs_trim_second_out),
		.prescaler_init(prescaler_init), .low_consumption(low_consumption), .detect_enable(detect_enable),
		.detect_ready(detect_ready), .main_osc_run(main_osc_run), .main_feedback_enable(main_feedback_enable),
		.cpu_src_main(cpu_src_main), .low_osc_run(low_osc_run), .all_clocks_stopped(all_clocks_stopped));
	// ------------------------------------------------------------------
	// Clock, pulse monitor and bus helpers
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Counting every high cycle catches both a missing and a stretched pulse.
	always @(posedge clock) if (prescaler_init === 1'b1) pulses <= pulses + 1;
	task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] wd, input logic [3:0] sel);
		int n;
		n = 0;
		@(posedge clock);
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'($random(seed)), wd};
		wb_we_i <= we;
		wb_sel_i <= sel;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin @(posedge clock); n++; end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o[7:0];
		if (n >= 20) begin n_errors++; $display("ERROR %0t: no acknowledge", $time); end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		// Outputs follow their register one clock later, so let two edges pass before looking.
		repeat (2) @(posedge clock);
		#1;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d, 4'h1);
	endtask : wr
	task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e);
		bus(idx, 1'b0, 8'h00, 4'hf);
		`CHK(rd, e)
	endtask : chk_rd
	task automatic do_reset(input logic strap);
		@(posedge clock);
		lvd0_autostart <= strap;
		rst <= 1'b1;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
	endtask : do_reset
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	initial begin
		#400000;
		n_errors++;
		complete_run();
	end
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		static logic [7:0] ix[12] = '{`OCC_IDX_HS_CTL, `OCC_IDX_HS_DIV, `OCC_IDX_TRIM_FIRST, `OCC_IDX_TRIM_SECOND,
			`OCC_IDX_PRESCALER, `OCC_IDX_TRIM36_FIRST, `OCC_IDX_TRIM36_SECOND, `OCC_IDX_TRIM32_FIRST,
			`OCC_IDX_TRIM32_SECOND, `OCC_IDX_PWR_DETECT, `OCC_IDX_SYSCLK, 8'h3f};
		static logic [7:0] ex[12] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h20, 8'h12, 8'h00};
		static logic [7:0] seq[6] = '{8'h01, 8'h03, 8'h0b, 8'h09, 8'h08, 8'h00};
		static logic [7:0] sw[7] = '{8'h1a, 8'h18, 8'h08, 8'h00, 8'h0c, 8'h16, 8'h1b};
		static logic [7:0] sr[7] = '{8'h1a, 8'h18, 8'h08, 8'h08, 8'h0c, 8'h1a, 8'h1b};
		static logic [4:0] sf[7] = '{5'b01010, 5'b11010, 5'b11110, 5'b11110, 5'b11100, 5'b01010, 5'b00001};
		{rst, wb_we_i, wb_cyc_i, wb_stb_i, lvd0_autostart, stop_wake} = 6'h20;
		wb_adr_i = 10'h000;
		wb_dat_i = 32'h00000000;
		wb_sel_i = 4'h0;
		do_reset(1'b0);
		for (int i = 0; i < 12; i++) chk_rd(ix[i], ex[i]);
		`CHK({hs_div_ratio, main_osc_run, hs_osc_run}, 6'h08)
		$display("test reset done");
		wr(`OCC_IDX_HS_CTL, 8'h03);
		chk_rd(`OCC_IDX_HS_CTL, 8'h00);
		wr(`OCC_IDX_PWR_DETECT, 8'h80);
		chk_rd(`OCC_IDX_PWR_DETECT, 8'h20);
		wr(`OCC_IDX_PROTECT, 8'h09);
		chk_rd(`OCC_IDX_PROTECT, 8'h09);
		bus(`OCC_IDX_HS_CTL, 1'b1, 8'h01, 4'he);
		chk_rd(`OCC_IDX_HS_CTL, 8'h00);
		$display("test protect done");
		// Enable first, select only while enabled, deselect before disabling in a later write.
		for (int i = 0; i < 6; i++) begin
			wr(`OCC_IDX_HS_CTL, seq[i]);
			`CHK({hs_osc_run, osc_clock_high_sel, div128_src_high}, {seq[i][0], seq[i][1], seq[i][3]})
		end
		for (int c = 0; c < 8; c++) begin
			wr(`OCC_IDX_HS_DIV, 8'(c));
			`CHK(hs_div_ratio, 4'(c + 2))
		end
		$display("test oscillator done");
		// Trims are rewritten only with the high-speed oscillator off.
		repeat (3) begin
			v = 8'($random(seed));
			wr(`OCC_IDX_TRIM_FIRST, v);
			wr(`OCC_IDX_TRIM_SECOND, ~v);
			`CHK({hs_trim_first_out, hs_trim_second_out}, {v, ~v})
		end
		for (int k = 0; k < 2; k++) begin
			bus(k ? `OCC_IDX_TRIM32_FIRST : `OCC_IDX_TRIM36_FIRST, 1'b0, 8'h00, 4'h1);
			wr(`OCC_IDX_TRIM_FIRST, rd);
			bus(k ? `OCC_IDX_TRIM32_SECOND : `OCC_IDX_TRIM36_SECOND, 1'b0, 8'h00, 4'h1);
			wr(`OCC_IDX_TRIM_SECOND, rd);
			`CHK({hs_trim_first_out, hs_trim_second_out}, k ? 16'h3344 : 16'h1122)
		end
		pulses = 0;
		wr(`OCC_IDX_PRESCALER, 8'h80);
		chk_rd(`OCC_IDX_PRESCALER, 8'h00);
		wr(`OCC_IDX_PRESCALER, 8'h7f);
		`CHK(pulses, 1)
		$display("test trim and prescaler done");
		wr(`OCC_IDX_PWR_DETECT, 8'he1);
		`CHK({detect_enable, low_consumption, detect_ready}, 7'b1111001)
		repeat (DELAY + 4) @(posedge clock);
		#1;
		`CHK(detect_ready, 3'b111)
		chk_rd(`OCC_IDX_STATUS, 8'h72);
		wr(`OCC_IDX_PWR_DETECT, 8'h20);
		`CHK({detect_enable, low_consumption, detect_ready}, 7'b0010001)
		$display("test detect done");
		wr(`OCC_IDX_HS_CTL, 8'h01);
		for (int i = 0; i < 7; i++) begin
			wr(`OCC_IDX_SYSCLK, sw[i]);
			chk_rd(`OCC_IDX_SYSCLK, sr[i]);
			fl = {main_osc_run, main_feedback_enable, cpu_src_main, low_osc_run, all_clocks_stopped};
			`CHK(fl, sf[i])
		end
		`CHK(hs_osc_run, 1'b0)
		@(posedge clock) stop_wake <= 1'b1;
		@(posedge clock) stop_wake <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		`CHK({all_clocks_stopped, hs_osc_run}, 2'b01)
		$display("test main oscillator done");
		do_reset(1'b1);
		chk_rd(`OCC_IDX_PWR_DETECT, 8'h00);
		chk_rd(`OCC_IDX_SYSCLK, 8'h12);
		`CHK(main_osc_run, 1'b0)
		$display("test strap reset done");
		complete_run();
	end
endmodule : occ_clock_control_tb
